// >>> core/amp_sup_defines.svh
// Purpose: constants for the amplifier supervisor and its controller
// Assumes: 250 MHz ref_clk; analog levels arrive as 100 mV codes
// Notes: start-up and dc qualify counts derive from the printed times
//------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------
`ifndef AMP_SUP_DEFINES_SVH
`define AMP_SUP_DEFINES_SVH
`define CLK_MHZ 250
`define STARTUP_MS 10
`define STARTUP_CYC (`STARTUP_MS * 1000 * `CLK_MHZ)
`define DC_QUAL_MS 420
`define DC_QUAL_CYC (`DC_QUAL_MS * 1000 * `CLK_MHZ)
`define DC_DUTY_PCT 7'h3c
`define DC_OFS_NUM 32
`define DC_OFS_DEN 150
`define TRIP_TEMP_C 8'h96
`define UV_LIM 9'h02d
`define OV_LIM 9'h10e
`define PLIM_GAIN 4
`define FULL_DUTY 7'h64
`define RECOVER_CYC 16'h0010
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_FCOUNT 12'h008
`define CTRL_RUN 0
`define CTRL_AUTO 1
`define STAT_LIVE 0
`define STAT_STICKY 1
`define STAT_SHDN 2
`endif

// >>> core/amp_sup_pkg.sv
// Purpose: shared types for supervisor and controller
// Assumes: one-hot state codes
// Notes: constants live in amp_sup_defines.svh
package amp_sup_pkg;
  typedef enum logic [3:0] {
    ST_START = 4'h1,
    ST_OFF = 4'h2,
    ST_RUN = 4'h4,
    ST_HIZ = 4'h8
  } sup_state_t;
  typedef enum logic [2:0] {
    CT_HOLD = 3'h1,
    CT_RUN = 3'h2,
    CT_RECOVER = 3'h4
  } ctl_state_t;
  typedef logic [6:0] pct_t;
  typedef logic [8:0] volt_t;
endpackage : amp_sup_pkg

// >>> core/amp_link_if.sv
// Purpose: shutdown and fault wires between controller and amplifier
// Assumes: both ends clocked by the same ref_clk
// Notes: plain levels, no tristate
`timescale 1ns/1ps
interface amp_link_if;
  logic shutdown_n_input; // controller drives, low = shutdown
  logic fault_n_output; // amplifier drives, low = fault
  modport dev (input shutdown_n_input, output fault_n_output);
  modport ctl (output shutdown_n_input, input fault_n_output);
endinterface : amp_link_if

// >>> core/amp_protection_supervisor.sv
// Purpose: start-up, shutdown, power limit and fault latching
// Assumes: analog sensing gives digital codes synchronous to ref_clk
// Notes: rst_b stands for power-on
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "amp_sup_defines.svh"
module amp_protection_supervisor
  import amp_sup_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = `STARTUP_CYC,
  parameter int unsigned DC_QUAL_CYCLES = `DC_QUAL_CYC
) (
  input wire logic ref_clk, // 250 MHz
  input wire logic rst_b, // power-on reset
  amp_link_if.dev link, // shutdown in, fault out
  input wire logic [2:0] gain_role_select, // gain/role code
  input wire logic left_in_pos_gnd, // left pos tied to ground
  input wire logic left_in_neg_gnd, // left neg tied to ground
  input wire volt_t power_stage_supply, // supply, 100 mV units
  input wire volt_t power_limit_input, // limit pin, 100 mV units
  input wire pct_t duty_req_left, // requested duty, percent
  input wire pct_t duty_req_right, // requested duty, percent
  input wire logic pol_left, // left output polarity
  input wire logic pol_right, // right output polarity
  input wire volt_t offset_left, // left output offset
  input wire volt_t offset_right, // right output offset
  input wire logic over_current, // output short detected
  input wire logic [7:0] die_temp, // junction temp, deg C
  output logic out_enable, // power stage switching
  output logic out_hiz, // outputs high impedance
  output logic mute, // outputs muted
  output logic low_power, // low-current state
  output logic [2:0] gain_latched, // held gain code
  output logic parallel_bridge_mono, // mono mode latched
  output pct_t duty_out_left, // clamped duty
  output pct_t duty_out_right // clamped duty
);

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  function automatic pct_t clamp_duty(input pct_t req, input pct_t ceil);
    clamp_duty = (req > ceil) ? ceil : req;
  endfunction : clamp_duty

  // dc qualifier: high duty and offset at supply-scaled minimum
  function automatic logic dc_cond(input pct_t duty, input volt_t ofs,
                                   input volt_t sup);
    logic [17:0] lhs;
    logic [17:0] rhs;
    lhs = 18'(ofs) * 18'(`DC_OFS_DEN);
    rhs = 18'(sup) * 18'(`DC_OFS_NUM);
    dc_cond = (duty > `DC_DUTY_PCT) && (lhs >= rhs);
  endfunction : dc_cond

  function automatic logic [26:0] dc_next(input logic cond,
                                          input logic pol,
                                          input logic pol_prev,
                                          input logic [26:0] cnt);
    if (!cond || pol != pol_prev) begin
      dc_next = 27'h0;
    end else if (cnt != 27'h7ffffff) begin
      dc_next = cnt + 27'h1;
    end else begin
      dc_next = cnt;
    end
  endfunction : dc_next

  //----------------------------------------------------------------
  // state
  //----------------------------------------------------------------
  sup_state_t state_r, state_nxt;
  logic [21:0] start_cnt_r, start_cnt_nxt;
  logic [26:0] dc_cnt_l_r, dc_cnt_l_nxt;
  logic [26:0] dc_cnt_r_r, dc_cnt_r_nxt;
  logic pol_l_r, pol_l_nxt;
  logic pol_r_r, pol_r_nxt;
  logic oc_lat_r, oc_lat_nxt;
  logic ot_lat_r, ot_lat_nxt;
  logic dc_lat_r, dc_lat_nxt;
  logic [2:0] gain_r, gain_nxt;
  logic mono_r, mono_nxt;
  pct_t ceil_r, ceil_nxt;
  pct_t duty_l_r, duty_l_nxt;
  pct_t duty_r_r, duty_r_nxt;
  logic fault_n_r, fault_n_nxt;
  logic en_r, en_nxt;
  logic hiz_r, hiz_nxt;
  logic mute_r, mute_nxt;
  logic lowp_r, lowp_nxt;

  logic supply_bad;
  logic any_latch;
  logic dc_trip;
  logic [15:0] rail;
  logic [22:0] ratio;

  //----------------------------------------------------------------
  // next-state logic
  //----------------------------------------------------------------
  always_comb begin
    supply_bad = (power_stage_supply < `UV_LIM) ||
                 (power_stage_supply > `OV_LIM);
    rail = 16'(power_limit_input) * 16'(`PLIM_GAIN);
    ratio = 23'h0;
    if (power_stage_supply != 9'h0) begin
      ratio = 23'((23'(rail) * 23'(`FULL_DUTY)) /
                  23'(power_stage_supply));
    end
    ceil_nxt = (ratio >= 23'(`FULL_DUTY)) ? `FULL_DUTY : pct_t'(ratio);

    state_nxt = state_r;
    start_cnt_nxt = start_cnt_r;
    gain_nxt = gain_r;
    mono_nxt = mono_r;
    pol_l_nxt = pol_left;
    pol_r_nxt = pol_right;
    dc_cnt_l_nxt = 27'h0;
    dc_cnt_r_nxt = 27'h0;
    if (state_r == ST_RUN) begin
      dc_cnt_l_nxt = dc_next(dc_cond(duty_req_left, offset_left,
                                     power_stage_supply),
                             pol_left, pol_l_r, dc_cnt_l_r);
      dc_cnt_r_nxt = dc_next(dc_cond(duty_req_right, offset_right,
                                     power_stage_supply),
                             pol_right, pol_r_r, dc_cnt_r_r);
    end
    dc_trip = (dc_cnt_l_r >= 27'(DC_QUAL_CYCLES)) ||
              (dc_cnt_r_r >= 27'(DC_QUAL_CYCLES));

    // set beats the shutdown clear
    oc_lat_nxt = over_current ||
                 (oc_lat_r && link.shutdown_n_input);
    ot_lat_nxt = (die_temp > `TRIP_TEMP_C) ||
                 (ot_lat_r && link.shutdown_n_input);
    dc_lat_nxt = dc_trip ||
                 (dc_lat_r && link.shutdown_n_input);
    // next latch values, so hiz, enable and fault move on one edge
    any_latch = oc_lat_nxt || ot_lat_nxt || dc_lat_nxt;

    case (state_r)
      ST_START: begin
        if (start_cnt_r >= 22'(STARTUP_CYCLES - 1)) begin
          gain_nxt = gain_role_select;
          mono_nxt = left_in_pos_gnd && left_in_neg_gnd;
          state_nxt = ST_OFF;
        end else begin
          start_cnt_nxt = start_cnt_r + 22'h1;
        end
      end
      ST_OFF: begin
        if (link.shutdown_n_input && (any_latch || supply_bad)) begin
          state_nxt = ST_HIZ;
        end else if (link.shutdown_n_input) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!link.shutdown_n_input) begin
          state_nxt = ST_OFF;
        end else if (any_latch || supply_bad) begin
          state_nxt = ST_HIZ;
        end
      end
      ST_HIZ: begin
        if (!link.shutdown_n_input) begin
          state_nxt = ST_OFF;
        end else if (!any_latch && !supply_bad) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_START;
      end
    endcase

    en_nxt = (state_nxt == ST_RUN);
    fault_n_nxt = !any_latch;
    // a held latch keeps the stage off the load even in shutdown
    hiz_nxt = (state_nxt == ST_HIZ) || (state_nxt == ST_START) ||
              !fault_n_nxt;
    mute_nxt = (state_nxt != ST_RUN);
    lowp_nxt = (state_nxt == ST_OFF);
    duty_l_nxt = 7'h0;
    duty_r_nxt = 7'h0;
    if (state_nxt == ST_RUN) begin
      // mono uses only the right input pair
      duty_r_nxt = clamp_duty(duty_req_right, ceil_r);
      duty_l_nxt = mono_r ? duty_r_nxt
                          : clamp_duty(duty_req_left, ceil_r);
    end
  end

  //----------------------------------------------------------------
  // registers
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_START;
      start_cnt_r <= 22'h0;
      dc_cnt_l_r <= 27'h0;
      dc_cnt_r_r <= 27'h0;
      pol_l_r <= 1'b0;
      pol_r_r <= 1'b0;
      oc_lat_r <= 1'b0;
      ot_lat_r <= 1'b0;
      dc_lat_r <= 1'b0;
      gain_r <= 3'h0;
      mono_r <= 1'b0;
      ceil_r <= 7'h0;
      duty_l_r <= 7'h0;
      duty_r_r <= 7'h0;
      fault_n_r <= 1'b1;
      en_r <= 1'b0;
      hiz_r <= 1'b1;
      mute_r <= 1'b1;
      lowp_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_cnt_r <= start_cnt_nxt;
      dc_cnt_l_r <= dc_cnt_l_nxt;
      dc_cnt_r_r <= dc_cnt_r_nxt;
      pol_l_r <= pol_l_nxt;
      pol_r_r <= pol_r_nxt;
      oc_lat_r <= oc_lat_nxt;
      ot_lat_r <= ot_lat_nxt;
      dc_lat_r <= dc_lat_nxt;
      gain_r <= gain_nxt;
      mono_r <= mono_nxt;
      ceil_r <= ceil_nxt;
      duty_l_r <= duty_l_nxt;
      duty_r_r <= duty_r_nxt;
      fault_n_r <= fault_n_nxt;
      en_r <= en_nxt;
      hiz_r <= hiz_nxt;
      mute_r <= mute_nxt;
      lowp_r <= lowp_nxt;
    end
  end

  assign link.fault_n_output = fault_n_r;
  assign out_enable = en_r;
  assign out_hiz = hiz_r;
  assign mute = mute_r;
  assign low_power = lowp_r;
  assign gain_latched = gain_r;
  assign parallel_bridge_mono = mono_r;
  assign duty_out_left = duty_l_r;
  assign duty_out_right = duty_r_r;

endmodule : amp_protection_supervisor

// >>> core/amp_system_controller.sv
// Purpose: drives shutdown, watches fault, APB register slave
// Assumes: software enables run once inputs settle
// Notes: one wait state on every APB access
`timescale 1ns/1ps
`include "amp_sup_defines.svh"
module amp_system_controller
  import amp_sup_pkg::*;
(
  input wire logic ref_clk, // 250 MHz
  input wire logic rst_b, // async reset
  amp_link_if.ctl link, // shutdown out, fault in
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error, unmapped
);

  ctl_state_t state_r, state_nxt;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic sticky_r, sticky_nxt;
  logic [7:0] fcount_r, fcount_nxt;
  logic [15:0] rec_cnt_r, rec_cnt_nxt;
  logic shdn_n_r, shdn_n_nxt;
  logic fault_d_r, fault_d_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic acc;
  logic wr;
  logic mapped;
  logic fault_edge;

  //----------------------------------------------------------------
  // next-state logic
  //----------------------------------------------------------------
  always_comb begin
    acc = psel && penable && !pready_r;
    wr = psel && penable && pready_r && pwrite && !pslverr_r;
    mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) ||
             (paddr == `REG_FCOUNT);
    fault_d_nxt = !link.fault_n_output;
    fault_edge = !link.fault_n_output && !fault_d_r;

    ctrl_nxt = ctrl_r;
    if (wr && paddr == `REG_CTRL) begin
      ctrl_nxt = pwdata[1:0];
    end
    // write-one clears sticky; a new fault edge wins
    sticky_nxt = sticky_r;
    if (wr && paddr == `REG_STATUS && pwdata[`STAT_STICKY]) begin
      sticky_nxt = 1'b0;
    end
    if (fault_edge) begin
      sticky_nxt = 1'b1;
    end
    fcount_nxt = fcount_r;
    if (fault_edge && fcount_r != 8'hff) begin
      fcount_nxt = fcount_r + 8'h1;
    end

    pready_nxt = acc;
    pslverr_nxt = acc && !mapped;
    prdata_nxt = 32'h0;
    if (acc && !pwrite) begin
      case (paddr)
        `REG_CTRL: prdata_nxt = {30'h0, ctrl_r};
        `REG_STATUS: prdata_nxt = {29'h0, !shdn_n_r, sticky_r,
                                   !link.fault_n_output};
        `REG_FCOUNT: prdata_nxt = {24'h0, fcount_r};
        default: prdata_nxt = 32'h0;
      endcase
    end

    state_nxt = state_r;
    rec_cnt_nxt = 16'h0;
    case (state_r)
      CT_HOLD: begin
        if (ctrl_r[`CTRL_RUN]) begin
          state_nxt = CT_RUN;
        end
      end
      CT_RUN: begin
        if (!ctrl_r[`CTRL_RUN]) begin
          state_nxt = CT_HOLD;
        end else if (!link.fault_n_output && ctrl_r[`CTRL_AUTO]) begin
          state_nxt = CT_RECOVER;
        end
      end
      CT_RECOVER: begin
        rec_cnt_nxt = rec_cnt_r + 16'h1;
        if (rec_cnt_r >= `RECOVER_CYC - 16'h1) begin
          state_nxt = ctrl_r[`CTRL_RUN] ? CT_RUN : CT_HOLD;
        end
      end
      default: begin
        state_nxt = CT_HOLD;
      end
    endcase
    shdn_n_nxt = (state_nxt == CT_RUN);
  end

  //----------------------------------------------------------------
  // registers
  //----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= CT_HOLD;
      ctrl_r <= 2'h0;
      sticky_r <= 1'b0;
      fcount_r <= 8'h0;
      rec_cnt_r <= 16'h0;
      shdn_n_r <= 1'b0;
      fault_d_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      sticky_r <= sticky_nxt;
      fcount_r <= fcount_nxt;
      rec_cnt_r <= rec_cnt_nxt;
      shdn_n_r <= shdn_n_nxt;
      fault_d_r <= fault_d_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign link.shutdown_n_input = shdn_n_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

endmodule : amp_system_controller

// >>> sim/amp_sup_assertions.sv
// Purpose: concurrent checks on the shutdown/fault link and stage state
// Assumes: one clock domain, rst_b asynchronous active low
// Notes: instantiated beside the link interface, no bind
`timescale 1ns/1ps
module amp_sup_assertions
  import amp_sup_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_b, // reset
  input wire logic shutdown_n_input, // link, from controller
  input wire logic fault_n_output, // link, from supervisor
  input wire logic over_current, // short trip
  input wire logic [7:0] die_temp, // junction temp
  input wire volt_t power_stage_supply, // supply level
  input wire logic out_enable, // stage switching
  input wire logic out_hiz, // stage high impedance
  input wire logic mute, // muted
  input wire logic low_power, // low-current state
  input wire logic [2:0] gain_latched, // held gain
  input wire logic parallel_bridge_mono // held mono flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_oc_trip;
    out_enable && over_current |=> !fault_n_output && out_hiz;
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("short no trip");
  property p_ot_trip;
    out_enable && die_temp > 8'h96 |=> !fault_n_output && out_hiz;
  endproperty
  a_ot_trip: assert property (p_ot_trip) else $error("temp no trip");
  property p_fault_off;
    !fault_n_output |-> !out_enable;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("runs in fault");
  property p_fault_stand;
    !fault_n_output && shutdown_n_input |=> !fault_n_output;
  endproperty
  a_fault_stand: assert property (p_fault_stand) else $error("latch lost");
  property p_fault_clear;
    !fault_n_output && !shutdown_n_input && !over_current &&
      die_temp <= 8'h96 |-> ##[1:2] fault_n_output;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("no clear");
  property p_supply_bad;
    out_enable && fault_n_output && !over_current &&
      power_stage_supply < 9'h02d |=> out_hiz && fault_n_output;
  endproperty
  a_supply_bad: assert property (p_supply_bad) else $error("uv wrong");
  property p_shdn_mute;
    out_enable && !shutdown_n_input |=> mute && low_power && !out_enable;
  endproperty
  a_shdn_mute: assert property (p_shdn_mute) else $error("no mute");
  property p_run_needs_sd;
    out_enable |-> $past(shutdown_n_input);
  endproperty
  a_run_needs_sd: assert property (p_run_needs_sd) else $error("run in sd");
  property p_cfg_held;
    !out_hiz && $past(low_power) |->
      $stable(gain_latched) && $stable(parallel_bridge_mono);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("cfg moved");
endmodule : amp_sup_assertions

// >>> sim/test_amp_protection_supervisor.sv
// Purpose: self-checking bench, supervisor and controller back to back
// Assumes: short start-up and dc qualify counts for simulation
// Notes: software view through apb only
`timescale 1ns/1ps
module test_amp_protection_supervisor
  import amp_sup_pkg::*;
;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, err_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_r;
  logic [2:0] gain_sel, gain_latched;
  logic lp_gnd, ln_gnd, oc, pol_l, pol_r;
  logic out_enable, out_hiz, mute, low_power, mono;
  logic [7:0] temp;
  volt_t sup, plim, ofs_l, ofs_r;
  pct_t dreq_l, dreq_r, dout_l, dout_r;
  volt_t bad [2];
  int n_errors, tests_run;
  amp_link_if link();
  amp_protection_supervisor #(.STARTUP_CYCLES(50), .DC_QUAL_CYCLES(40))
    u_amp_protection_supervisor (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link), .gain_role_select(gain_sel), .left_in_pos_gnd(lp_gnd),
    .left_in_neg_gnd(ln_gnd), .power_stage_supply(sup),
    .power_limit_input(plim), .duty_req_left(dreq_l),
    .duty_req_right(dreq_r), .pol_left(pol_l), .pol_right(pol_r),
    .offset_left(ofs_l), .offset_right(ofs_r), .over_current(oc),
    .die_temp(temp), .out_enable(out_enable), .out_hiz(out_hiz),
    .mute(mute), .low_power(low_power), .gain_latched(gain_latched),
    .parallel_bridge_mono(mono), .duty_out_left(dout_l),
    .duty_out_right(dout_r));
  amp_system_controller u_amp_system_controller (.ref_clk(ref_clk),
    .rst_b(rst_b), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  amp_sup_assertions u_amp_sup_assertions (.ref_clk(ref_clk),
    .rst_b(rst_b), .shutdown_n_input(link.shutdown_n_input),
    .fault_n_output(link.fault_n_output), .over_current(oc),
    .die_temp(temp), .power_stage_supply(sup), .out_enable(out_enable),
    .out_hiz(out_hiz), .mute(mute), .low_power(low_power),
    .gain_latched(gain_latched), .parallel_bridge_mono(mono));
  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  function automatic logic [31:0] b(input logic x);
    return {31'h0, x};
  endfunction : b
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge ref_clk);
    end
    rd_r = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) chk("pready", 32'h1, 32'h0);
  endtask : apb
  task wait_run();
    int k;
    k = 0;
    while (out_enable !== 1'b1 && k < 60) begin
      tk(1);
      k++;
    end
    chk("out_enable", 32'h1, b(out_enable));
  endtask : wait_run
  task final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  //------------------------------------------------------------------
  // clock, watchdog, tests
  //------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    n_errors = 0;
    tests_run = 0;
    rst_b = 1'b0;
    {psel, penable, pwrite, oc, pol_l, pol_r} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gain_sel = 3'h5;
    {lp_gnd, ln_gnd} = 2'b11;
    sup = 9'h078;
    plim = 9'h00f;
    {ofs_l, ofs_r} = '0;
    dreq_l = 7'h5f;
    dreq_r = 7'h14;
    temp = 8'h19;
    bad = '{9'h028, 9'h10f};
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    tk(10);
    chk("start hiz", 32'h1, b(out_hiz));
    tk(50);
    chk("off", 32'h1, b(low_power));
    chk("gain", 32'h5, {29'h0, gain_latched});
    chk("mono", 32'h1, b(mono));
    @(posedge ref_clk);
    gain_sel <= 3'h2;
    lp_gnd <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 32'h1, b(err_r));
    apb(1'b1, 12'h000, 32'h1);
    wait_run();
    tk(3);
    chk("duty r", 32'h14, {25'h0, dout_r});
    chk("duty l", 32'h14, {25'h0, dout_l});
    dreq_r <= 7'h5a;
    tk(4);
    chk("ceiling", 32'h32, {25'h0, dout_r});
    chk("gain held", 32'h5, {29'h0, gain_latched});
    $display("test startup and limit done");
    foreach (bad[i]) begin
      sup <= bad[i];
      tk(3);
      chk("supply hiz", 32'h1, b(out_hiz));
      chk("supply fault", 32'h1, b(link.fault_n_output));
      sup <= 9'h078;
      wait_run();
    end
    $display("test supply done");
    oc <= 1'b1;
    @(posedge ref_clk);
    oc <= 1'b0;
    tk(3);
    chk("short fault", 32'h0, b(link.fault_n_output));
    chk("short hiz", 32'h1, b(out_hiz));
    tk(20);
    chk("short held", 32'h0, b(link.fault_n_output));
    apb(1'b1, 12'h000, 32'h0);
    tk(4);
    chk("short clear", 32'h1, b(link.fault_n_output));
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h6, rd_r);
    apb(1'b0, 12'h008, 32'h0);
    chk("fcount", 32'h1, rd_r);
    $display("test short done");
    temp <= 8'h96;
    apb(1'b1, 12'h000, 32'h3);
    wait_run();
    chk("temp edge", 32'h1, b(link.fault_n_output));
    temp <= 8'h97;
    tk(2);
    temp <= 8'h19;
    chk("temp fault", 32'h0, b(link.fault_n_output));
    wait_run();
    chk("recovered", 32'h1, b(link.fault_n_output));
    $display("test temp done");
    apb(1'b1, 12'h000, 32'h1);
    plim <= 9'h01e;
    dreq_l <= 7'h46;
    dreq_r <= 7'h46;
    ofs_l <= 9'h014;
    ofs_r <= 9'h014;
    tk(60);
    chk("dc low ofs", 32'h1, b(link.fault_n_output));
    ofs_l <= 9'h01e;
    ofs_r <= 9'h01e;
    tk(45);
    chk("dc fault", 32'h0, b(link.fault_n_output));
    chk("dc hiz", 32'h1, b(out_hiz));
    dreq_l <= 7'h14;
    dreq_r <= 7'h14;
    apb(1'b1, 12'h000, 32'h0);
    tk(4);
    chk("dc clear", 32'h1, b(link.fault_n_output));
    apb(1'b1, 12'h000, 32'h1);
    wait_run();
    $display("test dc done");
    apb(1'b1, 12'h000, 32'h0);
    tk(3);
    chk("shdn mute", 32'h1, b(mute));
    chk("shdn lowp", 32'h1, b(low_power));
    chk("shdn run", 32'h0, b(out_enable));
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    tk(60);
    chk("regain", 32'h2, {29'h0, gain_latched});
    chk("remono", 32'h0, b(mono));
    $display("test shutdown and power-up done");
    final_report();
  end
endmodule : test_amp_protection_supervisor
